// [common/sita_regs.svh]
// register offsets, field positions and reset values of the table access register slice
// ****************************************************************
// What this block does
// - tos codes 0x3c..0x3f take their 2-bit priority from the last map register
// - the programmed 48-bit switch address is the pause frame source address
// - switch address stored msb first, lowest offset bits 47-40, all read/write
// - three 8-bit scratch registers, read/write, reset zero, never used by hardware
// - indirect window reaches static, vlan, dynamic address tables and mib counters
// - control bit 4 set means table read, clear means table write, resets zero
// - control bits 3-2 pick table: 00 static, 01 vlan, 10 dynamic, 11 mib
// - table address is 10 bits: control bits 1-0 high, low register low
// - writing the low address register launches the command at once, except while a read is pending
// - top data bit 7 reads one while a dynamic or mib read is pending
// - indirect data is 67 bits; bits 66-64 read-only in top register bits 2-0
// - eight data bytes read/write, feed writes, take read results, reset zero
// ****************************************************************
`ifndef SITA_REGS_SVH
`define SITA_REGS_SVH

`define SITA_OFF_PRIO_MAP 8'h6f
`define SITA_OFF_ADDR_B0 8'h70
`define SITA_OFF_ADDR_B1 8'h71
`define SITA_OFF_ADDR_B2 8'h72
`define SITA_OFF_ADDR_B3 8'h73
`define SITA_OFF_ADDR_B4 8'h74
`define SITA_OFF_ADDR_B5 8'h75
`define SITA_OFF_SCRATCH_A 8'h76
`define SITA_OFF_SCRATCH_B 8'h77
`define SITA_OFF_SCRATCH_C 8'h78
`define SITA_OFF_CTRL 8'h79
`define SITA_OFF_ADDR_LOW 8'h7a
`define SITA_OFF_DATA_TOP 8'h7b
`define SITA_OFF_DATA_B7 8'h7c
`define SITA_OFF_DATA_B6 8'h7d
`define SITA_OFF_DATA_B5 8'h7e
`define SITA_OFF_DATA_B4 8'h7f
`define SITA_OFF_DATA_B3 8'h80
`define SITA_OFF_DATA_B2 8'h81
`define SITA_OFF_DATA_B1 8'h82
`define SITA_OFF_DATA_B0 8'h83

`define SITA_CTRL_DIR_BIT 4
`define SITA_CTRL_SEL_HI 3
`define SITA_CTRL_SEL_LO 2
`define SITA_CTRL_AHI_HI 1
`define SITA_CTRL_AHI_LO 0
`define SITA_TOP_BUSY_BIT 7
`define SITA_PRIO_CODE_TOP 4'hf

`define SITA_RST_BYTE 8'h00
`define SITA_RST_ADDR_HI3 8'hff

`endif

// [common/sita_pkg.sv]
// types shared by the table access register slice
package sita_pkg;

	typedef enum logic [1:0] {
		SITA_TBL_STATIC = 2'b00,
		SITA_TBL_VLAN = 2'b01,
		SITA_TBL_DYNAMIC = 2'b10,
		SITA_TBL_MIB = 2'b11
	} sita_tbl_e;

	typedef enum logic {
		SITA_IDLE = 1'b0,
		SITA_WAIT = 1'b1
	} sita_fsm_e;

	typedef struct packed {
		logic [7:0] prio_map;
		logic [5:0][7:0] sw_addr;
		logic [2:0][7:0] scratch;
		logic [2:0] ctrl_rsvd;
		logic dir_read;
		sita_tbl_e tbl_sel;
		logic [1:0] addr_hi;
		logic [7:0] addr_lo;
		logic [2:0] data_top;
		logic [7:0][7:0] data;
		sita_fsm_e fsm;
		sita_tbl_e pend_sel;
		logic [7:0] rdata;
		logic req;
		logic req_read;
		sita_tbl_e req_sel;
		logic [9:0] req_addr;
		logic [63:0] req_wdata;
		logic prio_valid;
		logic prio_hit;
		logic [1:0] prio;
	} sita_state_s;

endpackage

// [logic/sita_regbank.sv]
// table access register slice: priority map, switch address, scratch and indirect window
`timescale 1ns/100ps
`include "sita_regs.svh"

module sita_regbank #(
	parameter logic [7:0] ADDR_B0_RST = 8'h02, // arbitrary value
	parameter logic [7:0] ADDR_B1_RST = 8'h55, // arbitrary value
	parameter logic [7:0] ADDR_B2_RST = 8'h66, // arbitrary value
	parameter int DATA_BYTES = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	// ****************************************************************
	// register port
	// ****************************************************************
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	// ****************************************************************
	// table engine side
	// ****************************************************************
	output logic tbl_req_q,
	output logic tbl_read_q,
	output logic [1:0] tbl_sel_q,
	output logic [9:0] tbl_addr_q,
	output logic [63:0] tbl_wdata_q,
	input wire logic tbl_done,
	input wire logic [66:0] tbl_rdata,
	// ****************************************************************
	// frame side
	// ****************************************************************
	input wire logic tos_valid,
	input wire logic [5:0] tos_code,
	output logic prio_valid_q,
	output logic prio_hit_q,
	output logic [1:0] prio_q,
	output logic [47:0] switch_station_address_q,
	output logic [23:0] scratch_registers_q
);

	sita_pkg::sita_state_s st_q;
	sita_pkg::sita_state_s st_d;

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	// data window is fixed at eight bytes
	if (DATA_BYTES != 8) begin : g_bad_width
		$error("data window must be eight bytes wide");
	end
	// offset spans the decoders rely on
	if (`SITA_OFF_ADDR_B5 - `SITA_OFF_ADDR_B0 != 8'h05) begin : g_bad_addr_span
		$error("switch address must span six offsets");
	end
	if (`SITA_OFF_SCRATCH_C - `SITA_OFF_SCRATCH_A != 8'h02) begin : g_bad_scratch_span
		$error("scratch registers must span three offsets");
	end
	if (`SITA_OFF_DATA_B0 - `SITA_OFF_DATA_B7 != 8'h07) begin : g_bad_data_span
		$error("data bytes must span eight offsets");
	end
	if (`SITA_OFF_ADDR_LOW != `SITA_OFF_CTRL + 8'h01) begin : g_bad_low_offset
		$error("low address must follow control");
	end
	if (`SITA_OFF_DATA_TOP != `SITA_OFF_ADDR_LOW + 8'h01) begin : g_bad_top_offset
		$error("top data register must follow low address");
	end
	// field positions the control packing relies on
	if (`SITA_CTRL_SEL_HI - `SITA_CTRL_SEL_LO != 1) begin : g_bad_sel_field
		$error("table select must be two bits");
	end
	if (`SITA_CTRL_AHI_HI - `SITA_CTRL_AHI_LO != 1) begin : g_bad_ahi_field
		$error("high address must be two bits");
	end
	if (`SITA_TOP_BUSY_BIT <= 2) begin : g_bad_busy_bit
		$error("busy bit must sit above the top data bits");
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic launch;
		st_d = st_q;
		launch = 1'b0;
		st_d.req = 1'b0;
		st_d.prio_valid = tos_valid;

		// priority lookup on every valid code, hit flagged for the top four codes only
		if (tos_valid) begin
			st_d.prio_hit = (tos_code[5:2] == `SITA_PRIO_CODE_TOP);
			st_d.prio = st_q.prio_map[{tos_code[1:0], 1'b0} +: 2];
		end

		// ****************************************************************
		// host writes
		// ****************************************************************
		if (reg_wr) begin
			case (reg_addr)
				`SITA_OFF_PRIO_MAP: begin
					st_d.prio_map = reg_wdata;
				end
				// byte 0 at the lowest offset holds the top of the address
				`SITA_OFF_ADDR_B0: begin
					st_d.sw_addr[5] = reg_wdata;
				end
				`SITA_OFF_ADDR_B1: begin
					st_d.sw_addr[4] = reg_wdata;
				end
				`SITA_OFF_ADDR_B2: begin
					st_d.sw_addr[3] = reg_wdata;
				end
				`SITA_OFF_ADDR_B3: begin
					st_d.sw_addr[2] = reg_wdata;
				end
				`SITA_OFF_ADDR_B4: begin
					st_d.sw_addr[1] = reg_wdata;
				end
				`SITA_OFF_ADDR_B5: begin
					st_d.sw_addr[0] = reg_wdata;
				end
				// scratch bytes are never read by the hardware
				`SITA_OFF_SCRATCH_A: begin
					st_d.scratch[0] = reg_wdata;
				end
				`SITA_OFF_SCRATCH_B: begin
					st_d.scratch[1] = reg_wdata;
				end
				`SITA_OFF_SCRATCH_C: begin
					st_d.scratch[2] = reg_wdata;
				end
				`SITA_OFF_CTRL: begin
					// upper bits stored as written so the host sees its own value
					st_d.ctrl_rsvd = reg_wdata[7:5];
					st_d.dir_read = reg_wdata[`SITA_CTRL_DIR_BIT];
					st_d.tbl_sel = sita_pkg::sita_tbl_e'(
						reg_wdata[`SITA_CTRL_SEL_HI:`SITA_CTRL_SEL_LO]);
					st_d.addr_hi = reg_wdata[`SITA_CTRL_AHI_HI:`SITA_CTRL_AHI_LO];
				end
				`SITA_OFF_ADDR_LOW: begin
					st_d.addr_lo = reg_wdata;
					launch = 1'b1;
				end
				// offset 0x7c carries bits 63-56
				`SITA_OFF_DATA_B7: begin
					st_d.data[7] = reg_wdata;
				end
				`SITA_OFF_DATA_B6: begin
					st_d.data[6] = reg_wdata;
				end
				`SITA_OFF_DATA_B5: begin
					st_d.data[5] = reg_wdata;
				end
				`SITA_OFF_DATA_B4: begin
					st_d.data[4] = reg_wdata;
				end
				`SITA_OFF_DATA_B3: begin
					st_d.data[3] = reg_wdata;
				end
				`SITA_OFF_DATA_B2: begin
					st_d.data[2] = reg_wdata;
				end
				`SITA_OFF_DATA_B1: begin
					st_d.data[1] = reg_wdata;
				end
				`SITA_OFF_DATA_B0: begin
					st_d.data[0] = reg_wdata;
				end
				default: begin
					// status register and unmapped offsets ignore writes
				end
			endcase
		end

		// ****************************************************************
		// indirect command engine
		// ****************************************************************
		case (st_q.fsm)
			sita_pkg::SITA_IDLE: begin
				if (launch) begin
					// control written in the same cycle is not yet in st_q; use current value
					st_d.req = 1'b1;
					st_d.req_read = st_q.dir_read;
					st_d.req_sel = st_q.tbl_sel;
					st_d.req_addr = {st_q.addr_hi, reg_wdata};
					st_d.req_wdata = st_q.data;
					if (st_q.dir_read) begin
						st_d.fsm = sita_pkg::SITA_WAIT;
						st_d.pend_sel = st_q.tbl_sel;
					end
				end
			end
			sita_pkg::SITA_WAIT: begin
				// a second launch while a read is pending is dropped
				if (tbl_done) begin
					st_d.data = tbl_rdata[63:0];
					st_d.data_top = tbl_rdata[66:64];
					st_d.fsm = sita_pkg::SITA_IDLE;
				end
			end
			default: begin
				st_d.fsm = sita_pkg::SITA_IDLE;
			end
		endcase

		// ****************************************************************
		// host reads
		// ****************************************************************
		if (reg_rd) begin
			case (reg_addr)
				`SITA_OFF_PRIO_MAP: begin
					st_d.rdata = st_q.prio_map;
				end
				// lowest offset returns the top address byte
				`SITA_OFF_ADDR_B0: begin
					st_d.rdata = st_q.sw_addr[5];
				end
				`SITA_OFF_ADDR_B1: begin
					st_d.rdata = st_q.sw_addr[4];
				end
				`SITA_OFF_ADDR_B2: begin
					st_d.rdata = st_q.sw_addr[3];
				end
				`SITA_OFF_ADDR_B3: begin
					st_d.rdata = st_q.sw_addr[2];
				end
				`SITA_OFF_ADDR_B4: begin
					st_d.rdata = st_q.sw_addr[1];
				end
				`SITA_OFF_ADDR_B5: begin
					st_d.rdata = st_q.sw_addr[0];
				end
				`SITA_OFF_SCRATCH_A: begin
					st_d.rdata = st_q.scratch[0];
				end
				`SITA_OFF_SCRATCH_B: begin
					st_d.rdata = st_q.scratch[1];
				end
				`SITA_OFF_SCRATCH_C: begin
					st_d.rdata = st_q.scratch[2];
				end
				// reserved bits read back as the host left them
				`SITA_OFF_CTRL: begin
					st_d.rdata = {st_q.ctrl_rsvd, st_q.dir_read, st_q.tbl_sel, st_q.addr_hi};
				end
				`SITA_OFF_ADDR_LOW: begin
					st_d.rdata = st_q.addr_lo;
				end
				`SITA_OFF_DATA_TOP: begin
					// busy only reported for the two slow tables
					st_d.rdata = 8'h00;
					st_d.rdata[`SITA_TOP_BUSY_BIT] = (st_q.fsm == sita_pkg::SITA_WAIT) &&
						(st_q.pend_sel == sita_pkg::SITA_TBL_DYNAMIC ||
						st_q.pend_sel == sita_pkg::SITA_TBL_MIB);
					st_d.rdata[2:0] = st_q.data_top;
				end
				// offset 0x7c returns bits 63-56
				`SITA_OFF_DATA_B7: begin
					st_d.rdata = st_q.data[7];
				end
				`SITA_OFF_DATA_B6: begin
					st_d.rdata = st_q.data[6];
				end
				`SITA_OFF_DATA_B5: begin
					st_d.rdata = st_q.data[5];
				end
				`SITA_OFF_DATA_B4: begin
					st_d.rdata = st_q.data[4];
				end
				`SITA_OFF_DATA_B3: begin
					st_d.rdata = st_q.data[3];
				end
				`SITA_OFF_DATA_B2: begin
					st_d.rdata = st_q.data[2];
				end
				`SITA_OFF_DATA_B1: begin
					st_d.rdata = st_q.data[1];
				end
				`SITA_OFF_DATA_B0: begin
					st_d.rdata = st_q.data[0];
				end
				default: begin
					// unmapped offsets read as zero
					st_d.rdata = 8'h00;
				end
			endcase
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q.prio_map <= `SITA_RST_BYTE;
			// upper three offsets reset to all ones, the rest come from parameters
			st_q.sw_addr <= {
				ADDR_B0_RST,
				ADDR_B1_RST,
				ADDR_B2_RST,
				`SITA_RST_ADDR_HI3,
				`SITA_RST_ADDR_HI3,
				`SITA_RST_ADDR_HI3};
			st_q.scratch <= '0;
			st_q.ctrl_rsvd <= 3'h0;
			st_q.dir_read <= 1'b0;
			st_q.tbl_sel <= sita_pkg::SITA_TBL_STATIC;
			st_q.addr_hi <= 2'h0;
			st_q.addr_lo <= `SITA_RST_BYTE;
			st_q.data_top <= 3'h0;
			st_q.data <= '0;
			st_q.fsm <= sita_pkg::SITA_IDLE;
			st_q.pend_sel <= sita_pkg::SITA_TBL_STATIC;
			st_q.rdata <= `SITA_RST_BYTE;
			st_q.req <= 1'b0;
			st_q.req_read <= 1'b0;
			st_q.req_sel <= sita_pkg::SITA_TBL_STATIC;
			st_q.req_addr <= 10'h000;
			st_q.req_wdata <= 64'h0000_0000_0000_0000;
			st_q.prio_valid <= 1'b0;
			st_q.prio_hit <= 1'b0;
			st_q.prio <= 2'h0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// outputs, all straight from the state register
	// ****************************************************************
	assign reg_rdata_q = st_q.rdata;
	assign tbl_req_q = st_q.req;
	assign tbl_read_q = st_q.req_read;
	assign tbl_sel_q = st_q.req_sel;
	assign tbl_addr_q = st_q.req_addr;
	assign tbl_wdata_q = st_q.req_wdata;
	assign prio_valid_q = st_q.prio_valid;
	assign prio_hit_q = st_q.prio_hit;
	assign prio_q = st_q.prio;
	assign switch_station_address_q = st_q.sw_addr;
	assign scratch_registers_q = st_q.scratch;

endmodule

// [verif/sita_regbank_asserts.sv]
// port checker for the table access register slice
`timescale 1ns/100ps
module sita_regbank_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic tbl_req_q,
	input wire logic [9:0] tbl_addr_q,
	input wire logic tos_valid,
	input wire logic [5:0] tos_code,
	input wire logic prio_hit_q,
	input wire logic [47:0] switch_station_address_q,
	input wire logic [23:0] scratch_registers_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_launch;
		reg_wr && reg_addr == 8'h7a ##1 tbl_req_q;
	endsequence
	AST_LAUNCH_CAUSE: assert property (tbl_req_q |-> $past(reg_wr) && $past(reg_addr) == 8'h7a)
		else $error("command without low address write");
	AST_REQ_PULSE: assert property (s_launch |=>
		!tbl_req_q || $past(reg_wr && reg_addr == 8'h7a))
		else $error("command longer than one cycle");
	AST_ADDR_LOW: assert property (s_launch |-> tbl_addr_q[7:0] == $past(reg_wdata))
		else $error("table address low byte wrong");
	AST_PRIO_HIT: assert property (tos_valid && tos_code >= 6'h3c |=> prio_hit_q)
		else $error("mapped code not hit");
	AST_PRIO_MISS: assert property (tos_valid && tos_code < 6'h3c |=> !prio_hit_q)
		else $error("unmapped code hit");
	AST_SCRATCH_WR: assert property (reg_wr && reg_addr == 8'h76 |=>
		scratch_registers_q[7:0] == $past(reg_wdata))
		else $error("scratch write lost");
	AST_SCRATCH_KEEP: assert property (!(reg_wr && reg_addr inside {[8'h76:8'h78]}) |=>
		$stable(scratch_registers_q))
		else $error("scratch changed by itself");
	AST_ADDR_KEEP: assert property (!(reg_wr && reg_addr inside {[8'h70:8'h75]}) |=>
		$stable(switch_station_address_q))
		else $error("switch address changed by itself");
	AST_RD_SCRATCH: assert property (reg_rd && reg_addr == 8'h77 |=>
		reg_rdata_q == $past(scratch_registers_q[15:8]))
		else $error("scratch readback wrong");
endmodule

bind sita_regbank sita_regbank_asserts i_chk (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .reg_rdata_q, .tbl_req_q, .tbl_addr_q, .tos_valid, .tos_code, .prio_hit_q,
	.switch_station_address_q, .scratch_registers_q);

// [verif/sita_tbl_model.sv]
// table engine stand-in answering indirect reads after a chosen delay
`timescale 1ns/100ps
module sita_tbl_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tbl_req_q,
	input wire logic tbl_read_q,
	input wire logic [9:0] tbl_addr_q,
	input wire logic [3:0] delay,
	output logic tbl_done,
	output logic [66:0] tbl_rdata
);
	logic [3:0] cnt_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= 4'h0;
			tbl_done <= 1'b0;
			tbl_rdata <= '0;
		end else begin
			tbl_done <= cnt_q == 4'h1;
			if (tbl_req_q && tbl_read_q)
				cnt_q <= delay;
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
			// toggles outside done so a stale capture cannot pass
			tbl_rdata <= cnt_q == 4'h1 ? {3'h5, 16'hc3a5, 38'h0, tbl_addr_q} : ~tbl_rdata;
		end
	end
endmodule

// [verif/tb.sv]
// self-checking bench for the table access register slice
`timescale 1ns/100ps
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin mismatches++; \
	$display("wrong value at %0t: %h not %h", $time, x, y); end end
module tb;
	logic clk, reset_n, reg_wr, reg_rd, tos_valid, tbl_done, tbl_req_q, tbl_read_q;
	logic prio_valid_q, prio_hit_q;
	logic [1:0] prio_q, tbl_sel_q;
	logic [3:0] delay;
	logic [5:0] tos_code;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q, v, e;
	logic [9:0] tbl_addr_q;
	logic [23:0] scratch_registers_q;
	logic [47:0] switch_station_address_q;
	logic [63:0] tbl_wdata_q;
	logic [66:0] tbl_rdata;
	int mismatches, checks, n;
	localparam logic [23:0] rows [16] = '{24'h6fa5a5, 24'h70a0a0, 24'h71b1b1, 24'h72c2c2,
		24'h73d3d3, 24'h74e4e4, 24'h75f5f5, 24'h760101, 24'h77fefe, 24'h785a5a, 24'h790b0b,
		24'h7c8181, 24'h837e7e, 24'h7bff00, 24'h90ff00, 24'h7a0000};
	sita_regbank i_dut (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q,
		.tbl_req_q, .tbl_read_q, .tbl_sel_q, .tbl_addr_q, .tbl_wdata_q, .tbl_done, .tbl_rdata,
		.tos_valid, .tos_code, .prio_valid_q, .prio_hit_q, .prio_q, .switch_station_address_q,
		.scratch_registers_q);
	sita_tbl_model i_tbl (.clk, .reset_n, .tbl_req_q, .tbl_read_q, .tbl_addr_q, .delay,
		.tbl_done, .tbl_rdata);
	task automatic complete_run;
		if (mismatches == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata_q;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		mismatches++;
		complete_run;
	end
	initial begin
		{reset_n, reg_wr, reg_rd, tos_valid, tos_code, reg_addr, reg_wdata} = '0;
		delay = 4'h1;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16]);
			`CHK(v, rows[i][7:0])
		end
		`CHK(switch_station_address_q, 48'ha0b1c2d3e4f5)
		`CHK(scratch_registers_q, 24'h5afe01)
		wr(8'h6f, 8'he4);
		for (int c = 8'h3b; c <= 8'h3f; c++) begin
			@(posedge clk);
			tos_valid <= 1'b1;
			tos_code <= c[5:0];
			@(posedge clk);
			tos_valid <= 1'b0;
			#1;
			`CHK({prio_valid_q, prio_hit_q}, {1'b1, c != 8'h3b})
			if (c != 8'h3b) `CHK(prio_q, 2'(c - 8'h3c))
		end
		wr(8'h7a, 8'h3c);
		`CHK({tbl_req_q, tbl_read_q, tbl_sel_q, tbl_addr_q}, {4'b1010, 10'h33c})
		`CHK(tbl_wdata_q, 64'h8100_0000_0000_007e)
		for (int s = 0; s < 4; s++) begin
			delay = s[1] ? 4'h8 : 4'h1;
			wr(8'h79, 8'h11 | 8'(s << 2));
			wr(8'h7a, 8'h40 + 8'(s));
			`CHK({tbl_req_q, tbl_read_q, tbl_sel_q, tbl_addr_q},
				{2'b11, 2'(s), 10'h140 + 10'(s)})
			if (s[1]) begin
				rd(8'h7b);
				`CHK(v[7], 1'b1)
				wr(8'h7a, 8'hff);
				`CHK(tbl_req_q, 1'b0)
			end
			n = 0;
			while (tbl_done !== 1'b1 && n < 40) begin
				@(posedge clk);
				#1;
				n++;
			end
			@(posedge clk);
			#1;
			rd(8'h7b);
			`CHK(v, 8'h05)
			rd(8'h7c);
			`CHK(v, 8'hc3)
			rd(8'h83);
			`CHK(v, 8'h40 + 8'(s))
		end
		// second reset in mid-run, then every mapped offset back at its reset value
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		for (int a = 8'h6f; a <= 8'h83; a++) begin
			rd(8'(a));
			e = a == 8'h70 ? 8'h02 : a == 8'h71 ? 8'h55 : a == 8'h72 ? 8'h66 : 8'h00;
			if (a >= 8'h73 && a <= 8'h75)
				e = 8'hff;
			`CHK(v, e)
		end
		complete_run;
	end
endmodule
